// ### mrc_pkg.sv
// Package with constants and types of the reset controller.
package mrc_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned WAIT_FCC_PERIODS = 56;
	localparam logic [7:0] WAIT_CYCLES = 8'(WAIT_FCC_PERIODS);
	localparam logic [12:0] VEC_ADDR_HI = 13'h0000;
	localparam logic [12:0] VEC_ADDR_LO = 13'h0001;
	localparam int unsigned PC_HI_LSB = 8;
	localparam int unsigned RBE_BIT = 6;
	localparam int unsigned MBE_BIT = 7;
	localparam logic [3:0] SBS_RESET = 4'h8;
	localparam logic [7:0] MODULO_RESET = 8'hff;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [3:0] ZERO4 = 4'h0;
	typedef enum logic [2:0] {
		MRC_HOLD = 3'b000,
		MRC_WAIT = 3'b001,
		MRC_FETCH_HI = 3'b011,
		MRC_FETCH_LO = 3'b010,
		MRC_RUN = 3'b110
	} mrc_state_t;
endpackage : mrc_pkg

// ### mrc_prog_mem_model.sv
// Program memory model that answers the vector fetch one cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none
module mrc_prog_mem_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic rd_in,
	input wire logic [12:0] addr_in,
	input wire logic [7:0] hi_in,
	input wire logic [7:0] lo_in,
	output logic [7:0] data_out
);
	// Outside a read the bus toggles every cycle, so a stale byte never looks like an answer.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			data_out <= 8'h5a;
		end else if (rd_in && addr_in == 13'h0000) begin
			data_out <= hi_in;
		end else if (rd_in && addr_in == 13'h0001) begin
			data_out <= lo_in;
		end else begin
			data_out <= ~data_out;
		end
	end
endmodule : mrc_prog_mem_model
`default_nettype wire

// ### mrc_reset_ctrl.sv
// Reset controller: merges reset sources, waits, fetches the vector, drives reset values.
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module mrc_reset_ctrl (
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic ext_reset_n_in,
	input wire logic wdt_reset_req_in,
	input wire logic standby_in,
	input wire logic [7:0] prog_rdata_in,
	output logic [12:0] prog_addr_out,
	output logic prog_rd_out,
	output logic internal_reset_out,
	output logic init_strobe_out,
	output logic preserve_state_out,
	output logic cpu_run_out,
	output logic [12:0] program_counter_out,
	output logic mem_bank_enable_out,
	output logic reg_bank_enable_out,
	output logic [2:0] skip_flags_out,
	output logic [1:0] int_status_flags_out,
	output logic [3:0] stack_bank_select_out,
	output logic [3:0] mem_bank_select_out,
	output logic [3:0] reg_bank_select_out,
	output logic [3:0] interval_mode_reg_out,
	output logic watchdog_enable_flag_out,
	output logic [7:0] timer0_count_out,
	output logic [7:0] timer0_modulo_out,
	output logic [7:0] timer0_mode_out,
	output logic timer0_out_enable_out,
	output logic timer0_out_flipflop_out,
	output logic [7:0] timer1_count_out,
	output logic [7:0] timer1_modulo_out,
	output logic [7:0] timer1_mode_out,
	output logic timer1_out_enable_out,
	output logic timer1_out_flipflop_out,
	output logic [7:0] clock_timer_mode_out,
	output logic [7:0] serial_op_mode_out,
	output logic [7:0] serial_bus_control_out,
	output logic [3:0] processor_clock_ctrl_out,
	output logic [3:0] system_clock_ctrl_out,
	output logic [3:0] clock_out_mode_out,
	output logic [3:0] sub_osc_ctrl_out,
	output logic clear_int_request_flags_out,
	output logic clear_int_enable_flags_out,
	output logic [3:0] int_priority_select_out,
	output logic [11:0] ext_int_edge_modes_out,
	output logic port_out_buffer_en_out,
	output logic clear_port_latches_out,
	output logic [11:0] port_io_modes_out,
	output logic [7:0] pullup_select_regs_out
);
	mrc_sync_if sync_if ();
	mrc_pkg::mrc_state_t state;
	mrc_pkg::mrc_state_t next_state;
	logic [7:0] wait_cnt;
	logic [7:0] next_wait_cnt;
	logic [7:0] vec_hi;
	logic [7:0] next_vec_hi;
	logic [12:0] pc;
	logic [12:0] next_pc;
	logic mem_bank_enable;
	logic next_mbe;
	logic reg_bank_enable;
	logic next_rbe;
	logic preserve;
	logic next_preserve;
	logic wdt_req;
	logic next_wdt_req;
	logic rst_active;
	logic in_reset;
	logic next_in_reset;

	assign sync_if.pin_rst_n_raw = ext_reset_n_in;

	mrc_sync u_sync (
		.clk_sys_in(clk_sys_in),
		.sys_rst_in(sys_rst_in),
		.port_if(sync_if.sync)
	);

	// Watchdog request is on the same clock, registered once to keep the merge glitch free.
	// The pin is read only behind the two-flop synchroniser, never raw.
	assign rst_active = !sync_if.pin_rst_n_sync || wdt_req;

	// Sequence group. A source seen active sends the controller to the hold state at the
	// next edge; once both sources are quiet it waits the fixed count of main clock periods,
	// reads the two vector bytes and only then lets the program run. A source that comes
	// back at any point restarts the whole sequence, so a cut fetch never starts a program.
	always_comb begin
		next_state = state;
		next_wait_cnt = wait_cnt;
		if (rst_active) begin
			// Any source restarts the sequence and holds it in reset.
			next_state = mrc_pkg::MRC_HOLD;
			next_wait_cnt = mrc_pkg::ZERO8;
		end else begin
			case (state)
				mrc_pkg::MRC_HOLD: begin
					next_state = mrc_pkg::MRC_WAIT;
					next_wait_cnt = mrc_pkg::ZERO8;
				end
				mrc_pkg::MRC_WAIT: begin
					next_wait_cnt = wait_cnt + 8'h01;
					if (wait_cnt == mrc_pkg::WAIT_CYCLES - 8'h01) begin
						next_state = mrc_pkg::MRC_FETCH_HI;
						next_wait_cnt = mrc_pkg::ZERO8;
					end
				end
				mrc_pkg::MRC_FETCH_HI: begin
					next_state = mrc_pkg::MRC_FETCH_LO;
				end
				mrc_pkg::MRC_FETCH_LO: begin
					next_state = mrc_pkg::MRC_RUN;
				end
				mrc_pkg::MRC_RUN: begin
					next_state = mrc_pkg::MRC_RUN;
				end
				default: begin
					next_state = mrc_pkg::MRC_HOLD;
					next_wait_cnt = mrc_pkg::ZERO8;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state <= mrc_pkg::MRC_HOLD;
			wait_cnt <= mrc_pkg::ZERO8;
		end else begin
			state <= next_state;
			wait_cnt <= next_wait_cnt;
		end
	end

	// Vector group: the two program bytes and what is taken from them.
	// The fetch steps only advance while no source is active.
	always_comb begin
		next_vec_hi = vec_hi;
		next_pc = pc;
		next_mbe = mem_bank_enable;
		next_rbe = reg_bank_enable;
		if (!rst_active && state == mrc_pkg::MRC_FETCH_HI) begin
			// Address 0000H was presented in the previous cycle; data arrives now.
			next_vec_hi = prog_rdata_in;
		end
		if (!rst_active && state == mrc_pkg::MRC_FETCH_LO) begin
			// The whole vector is taken in one cycle, so no half-loaded start address is seen.
			next_pc = {vec_hi[4:0], prog_rdata_in};
			next_rbe = vec_hi[mrc_pkg::RBE_BIT];
			next_mbe = vec_hi[mrc_pkg::MBE_BIT];
		end
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			vec_hi <= mrc_pkg::ZERO8;
			pc <= 13'h0000;
			mem_bank_enable <= 1'b0;
			reg_bank_enable <= 1'b0;
		end else begin
			vec_hi <= next_vec_hi;
			pc <= next_pc;
			mem_bank_enable <= next_mbe;
			reg_bank_enable <= next_rbe;
		end
	end

	// Source group: the watchdog request registered once, and the standby mark of the last
	// reset that stopped a running program.
	always_comb begin
		next_wdt_req = wdt_reset_req_in;
		next_preserve = preserve;
		if (rst_active && state == mrc_pkg::MRC_RUN) begin
			// Only the reset that stops a running program decides; restarts keep the mark.
			next_preserve = standby_in;
		end
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			preserve <= 1'b0;
			wdt_req <= 1'b0;
		end else begin
			preserve <= next_preserve;
			wdt_req <= next_wdt_req;
		end
	end

	// Reset line group: the internal reset comes from a flip-flop so the peripherals
	// never see a decode glitch while the state moves between codes.
	always_comb begin
		next_in_reset = (next_state != mrc_pkg::MRC_RUN);
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			in_reset <= 1'b1;
		end else begin
			in_reset <= next_in_reset;
		end
	end

	// Vector fetch: address 0000H is issued in the last wait cycle, 0001H in the next.
	// A source that returns mid-fetch drops the strobe at once, so no stray read is issued.
	always_comb begin
		prog_rd_out = 1'b0;
		prog_addr_out = mrc_pkg::VEC_ADDR_HI;
		if (state == mrc_pkg::MRC_WAIT && wait_cnt == mrc_pkg::WAIT_CYCLES - 8'h01
			&& !rst_active) begin
			prog_rd_out = 1'b1;
			prog_addr_out = mrc_pkg::VEC_ADDR_HI;
		end else if (state == mrc_pkg::MRC_FETCH_HI && !rst_active) begin
			prog_rd_out = 1'b1;
			prog_addr_out = mrc_pkg::VEC_ADDR_LO;
		end
	end

	assign internal_reset_out = in_reset;
	assign init_strobe_out = in_reset;
	// Blocks holding carry, RAM, registers, shift and slave address and bit buffers
	// keep contents when this is high; otherwise their contents are undefined.
	assign preserve_state_out = preserve;
	assign cpu_run_out = !in_reset;
	// Vector results stand from the first run cycle until a system reset clears them or the next sequence loads them.
	assign program_counter_out = pc;
	assign mem_bank_enable_out = mem_bank_enable;
	assign reg_bank_enable_out = reg_bank_enable;

	// Reset values offered to the peripheral blocks, loaded while init_strobe_out is high.
	assign skip_flags_out = 3'h0;
	assign int_status_flags_out = 2'h0;

	// Stack and bank selection.
	assign stack_bank_select_out = mrc_pkg::SBS_RESET;
	assign mem_bank_select_out = mrc_pkg::ZERO4;
	assign reg_bank_select_out = mrc_pkg::ZERO4;

	// Interval timer and watchdog.
	assign interval_mode_reg_out = mrc_pkg::ZERO4;
	assign watchdog_enable_flag_out = 1'b0;

	// Timer and event counter.
	assign timer0_count_out = mrc_pkg::ZERO8;
	assign timer0_modulo_out = mrc_pkg::MODULO_RESET;
	assign timer0_mode_out = mrc_pkg::ZERO8;
	assign timer0_out_enable_out = 1'b0;
	assign timer0_out_flipflop_out = 1'b0;

	// Timer counter.
	assign timer1_count_out = mrc_pkg::ZERO8;
	assign timer1_modulo_out = mrc_pkg::MODULO_RESET;
	assign timer1_mode_out = mrc_pkg::ZERO8;
	assign timer1_out_enable_out = 1'b0;
	assign timer1_out_flipflop_out = 1'b0;

	// Clock timer and serial interface.
	assign clock_timer_mode_out = mrc_pkg::ZERO8;
	assign serial_op_mode_out = mrc_pkg::ZERO8;
	assign serial_bus_control_out = mrc_pkg::ZERO8;

	// Clock generator, clock output and sub-oscillator.
	assign processor_clock_ctrl_out = mrc_pkg::ZERO4;
	assign system_clock_ctrl_out = mrc_pkg::ZERO4;
	assign clock_out_mode_out = mrc_pkg::ZERO4;
	assign sub_osc_ctrl_out = mrc_pkg::ZERO4;

	// Interrupt controller: request and enable flags clear while reset is held.
	assign clear_int_request_flags_out = in_reset;
	assign clear_int_enable_flags_out = in_reset;
	assign int_priority_select_out = mrc_pkg::ZERO4;
	assign ext_int_edge_modes_out = 12'h000;

	// Ports: buffers stay off and latches clear until the program runs.
	assign port_out_buffer_en_out = !in_reset;
	assign clear_port_latches_out = in_reset;
	assign port_io_modes_out = 12'h000;
	assign pullup_select_regs_out = mrc_pkg::ZERO8;
endmodule : mrc_reset_ctrl
`default_nettype wire

// ### mrc_reset_ctrl_checker.sv
// Assertions on the ports of the reset controller.
`timescale 1ns/10ps
`default_nettype none
module mrc_reset_ctrl_checker (
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic ext_reset_n_in,
	input wire logic wdt_reset_req_in,
	input wire logic [7:0] prog_rdata_in,
	input wire logic [12:0] prog_addr_out,
	input wire logic prog_rd_out,
	input wire logic internal_reset_out,
	input wire logic init_strobe_out,
	input wire logic preserve_state_out,
	input wire logic cpu_run_out,
	input wire logic [12:0] program_counter_out,
	input wire logic mem_bank_enable_out,
	input wire logic reg_bank_enable_out,
	input wire logic [2:0] skip_flags_out,
	input wire logic [3:0] stack_bank_select_out,
	input wire logic [7:0] timer0_modulo_out,
	input wire logic port_out_buffer_en_out
);
	logic [7:0] quiet;
	logic [7:0] byte_lo;
	logic [7:0] byte_hi;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	// Counts cycles since a reset source was last seen active.
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			quiet <= 8'h00;
		end else if (!ext_reset_n_in || wdt_reset_req_in) begin
			quiet <= 8'h00;
		end else if (quiet != 8'hff) begin
			quiet <= quiet + 8'h01;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		byte_lo <= prog_rdata_in;
		byte_hi <= byte_lo;
	end
	a_pin_resets: assert property (!ext_reset_n_in |-> ##[1:3] internal_reset_out)
		else $error("pin low did not raise internal reset");
	a_wdt_resets: assert property (wdt_reset_req_in |-> ##[1:2] internal_reset_out)
		else $error("watchdog request did not raise internal reset");
	a_wait_length: assert property (prog_rd_out && prog_addr_out == 13'h0000 |-> quiet >= 8'h39 && quiet <= 8'h3c)
		else $error("vector fetch started after wrong wait");
	a_fetch_order: assert property (prog_rd_out && prog_addr_out == 13'h0000 |=> prog_rd_out && prog_addr_out == 13'h0001 ##1 !prog_rd_out && internal_reset_out ##1 cpu_run_out)
		else $error("vector fetch order broken");
	a_vector_pc: assert property ($rose(cpu_run_out) |-> program_counter_out == {byte_hi[4:0], byte_lo})
		else $error("program counter not loaded from vector");
	a_bank_flags: assert property ($rose(cpu_run_out) |-> mem_bank_enable_out == byte_hi[7] && reg_bank_enable_out == byte_hi[6])
		else $error("bank enables not loaded from vector");
	a_init_values: assert property (internal_reset_out |-> skip_flags_out == 3'h0 && stack_bank_select_out == 4'h8 && timer0_modulo_out == 8'hff && !port_out_buffer_en_out)
		else $error("reset value missing during reset");
	a_preserve_hold: assert property (internal_reset_out [*3] |-> $stable(preserve_state_out))
		else $error("preserve flag changed inside a reset");
	a_run_state: assert property (cpu_run_out |-> !internal_reset_out && !init_strobe_out && !prog_rd_out && port_out_buffer_en_out)
		else $error("run state inconsistent");
	c_run: cover property ($rose(cpu_run_out));
	c_wdt: cover property (wdt_reset_req_in && cpu_run_out);
	c_pin: cover property (!ext_reset_n_in && cpu_run_out);
endmodule : mrc_reset_ctrl_checker
bind mrc_reset_ctrl mrc_reset_ctrl_checker u_chk (.*);
`default_nettype wire

// ### mrc_sync.sv
// Two-stage synchroniser for the external reset pin.
`timescale 1ns/10ps
`default_nettype none
module mrc_sync (
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	mrc_sync_if.sync port_if
);
	logic stage1;
	logic stage2;
	logic next_stage1;
	logic next_stage2;
	always_comb begin
		next_stage1 = port_if.pin_rst_n_raw;
		next_stage2 = stage1;
	end
	// Resets to the asserted level so the pin counts as active until sampled.
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
		end else begin
			stage1 <= next_stage1;
			stage2 <= next_stage2;
		end
	end
	assign port_if.pin_rst_n_sync = stage2;
endmodule : mrc_sync
`default_nettype wire

// ### mrc_sync_if.sv
// Interface carrying the external reset pin, raw and synchronised, between the synchroniser and the main controller.
`timescale 1ns/10ps
`default_nettype none
interface mrc_sync_if;
	logic pin_rst_n_raw;
	logic pin_rst_n_sync;
	modport sync (input pin_rst_n_raw, output pin_rst_n_sync);
	modport user (output pin_rst_n_raw, input pin_rst_n_sync);
endinterface : mrc_sync_if
`default_nettype wire

// ### test_mrc_reset_ctrl.sv
// Self-checking testbench of the reset controller.
`timescale 1ns/10ps
`default_nettype none
module test_mrc_reset_ctrl;
	typedef struct {logic [7:0] hi; logic [7:0] lo; logic src; logic [12:0] pc; logic [1:0] be;} mrc_row_t;
	logic clk_sys_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic ext_reset_n_in = 1'b1;
	logic wdt_reset_req_in = 1'b0;
	logic standby_in = 1'b0;
	logic [7:0] prog_rdata_in, vec_hi, vec_lo;
	logic [12:0] prog_addr_out, program_counter_out;
	logic prog_rd_out, internal_reset_out, init_strobe_out, preserve_state_out, cpu_run_out;
	logic mem_bank_enable_out, reg_bank_enable_out, watchdog_enable_flag_out;
	logic timer0_out_enable_out, timer0_out_flipflop_out, timer1_out_enable_out;
	logic timer1_out_flipflop_out, clear_int_request_flags_out, clear_int_enable_flags_out;
	logic port_out_buffer_en_out, clear_port_latches_out;
	logic [1:0] int_status_flags_out;
	logic [2:0] skip_flags_out;
	logic [3:0] stack_bank_select_out, mem_bank_select_out, reg_bank_select_out;
	logic [3:0] interval_mode_reg_out, processor_clock_ctrl_out, system_clock_ctrl_out;
	logic [3:0] clock_out_mode_out, sub_osc_ctrl_out, int_priority_select_out;
	logic [7:0] timer0_count_out, timer0_modulo_out, timer0_mode_out, timer1_count_out;
	logic [7:0] timer1_modulo_out, timer1_mode_out, clock_timer_mode_out, serial_op_mode_out;
	logic [7:0] serial_bus_control_out, pullup_select_regs_out;
	logic [11:0] ext_int_edge_modes_out, port_io_modes_out;
	int bad_count = 0;
	int check_count = 0;
	int n;
	mrc_row_t rows [4] = '{'{8'h00, 8'h00, 1'b0, 13'h0000, 2'h0}, '{8'hff, 8'hff, 1'b1, 13'h1fff, 2'h3},
		'{8'h5a, 8'h3c, 1'b0, 13'h1a3c, 2'h1}, '{8'ha5, 8'hc3, 1'b1, 13'h05c3, 2'h2}};
	mrc_reset_ctrl u_dut (.*);
	mrc_prog_mem_model u_mem (.clk_in(clk_sys_in), .rst_in(sys_rst_in), .rd_in(prog_rd_out),
		.addr_in(prog_addr_out), .hi_in(vec_hi), .lo_in(vec_lo), .data_out(prog_rdata_in));
	always #2 clk_sys_in = ~clk_sys_in;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	task automatic chk_init;
		chk(16'({stack_bank_select_out, timer0_modulo_out}), 16'h8ff, "stack bank, modulo 0");
		chk(16'(timer1_modulo_out), 16'h00ff, "modulo 1");
		chk(16'(|{skip_flags_out, int_status_flags_out, mem_bank_select_out, reg_bank_select_out}), 16'h0, "psw");
		chk(16'(|{interval_mode_reg_out, watchdog_enable_flag_out, timer0_count_out, timer0_mode_out,
			timer0_out_enable_out, timer0_out_flipflop_out, timer1_count_out, timer1_mode_out,
			timer1_out_enable_out, timer1_out_flipflop_out}), 16'h0, "timers");
		chk(16'(|{clock_timer_mode_out, serial_op_mode_out, serial_bus_control_out}), 16'h0, "serial");
		chk(16'(|{processor_clock_ctrl_out, system_clock_ctrl_out, clock_out_mode_out, sub_osc_ctrl_out}),
			16'h0, "clocks");
		chk(16'(|{int_priority_select_out, ext_int_edge_modes_out}), 16'h0, "interrupts");
		chk(16'({clear_int_request_flags_out, clear_int_enable_flags_out}), 16'h3, "irq clear");
		chk(16'(|{port_io_modes_out, pullup_select_regs_out, port_out_buffer_en_out}), 16'h0, "ports");
		chk(16'({clear_port_latches_out, init_strobe_out, cpu_run_out}), 16'h6, "strobes");
	endtask : chk_init
	task automatic wait_run;
		while (cpu_run_out !== 1'b1 && n < 300) begin
			@(posedge clk_sys_in);
			#1;
			n++;
		end
		if (n >= 300) begin
			bad_count++;
			test_done();
		end
	endtask : wait_run
	// Src 1 pulses the pin, src 0 the watchdog; n counts edges after the last active sample.
	task automatic fire(input logic src);
		@(posedge clk_sys_in);
		ext_reset_n_in <= !src;
		wdt_reset_req_in <= !src;
		@(posedge clk_sys_in);
		ext_reset_n_in <= 1'b1;
		wdt_reset_req_in <= 1'b0;
		n = 0;
		repeat (3) begin
			@(posedge clk_sys_in);
			#1;
			n++;
		end
		chk_init();
		wait_run();
		chk(16'(n), 16'(mrc_pkg::WAIT_FCC_PERIODS + 4 + 32'(src)), "release time");
	endtask : fire
	initial begin
		vec_hi = 8'h00;
		vec_lo = 8'h00;
		repeat (3) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		n = 0;
		wait_run();
		for (int i = 0; i < 4; i++) begin
			vec_hi = rows[i].hi;
			vec_lo = rows[i].lo;
			fire(rows[i].src);
			chk(16'(program_counter_out), 16'(rows[i].pc), "pc");
			chk(16'({mem_bank_enable_out, reg_bank_enable_out}), 16'(rows[i].be), "bank enables");
			chk(16'(preserve_state_out), 16'h0, "preserve after run reset");
		end
		@(posedge clk_sys_in);
		standby_in <= 1'b1;
		@(posedge clk_sys_in);
		wdt_reset_req_in <= 1'b1;
		@(posedge clk_sys_in);
		wdt_reset_req_in <= 1'b0;
		// The design takes the standby level one edge after the request is registered.
		@(posedge clk_sys_in);
		standby_in <= 1'b0;
		repeat (19) @(posedge clk_sys_in);
		#1;
		chk(16'(cpu_run_out), 16'h0, "still in reset");
		chk(16'(preserve_state_out), 16'h1, "preserve taken in standby");
		fire(1'b1);
		chk(16'(preserve_state_out), 16'h1, "preserve kept from first reset");
		@(posedge clk_sys_in);
		sys_rst_in <= 1'b1;
		@(posedge clk_sys_in);
		#1;
		chk(16'({internal_reset_out, program_counter_out}), 16'h2000, "system reset");
		@(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		n = 0;
		wait_run();
		chk(16'(n), 16'(mrc_pkg::WAIT_FCC_PERIODS + 5), "release time after system reset");
		chk(16'(program_counter_out), 16'h05c3, "pc after system reset");
		test_done();
	end
endmodule : test_mrc_reset_ctrl
`default_nettype wire
